// >>> rtl/bca_pkg.sv
package bca_pkg;

   // operation selected by the decode stage
   typedef enum logic [4:0] {
      op_add,
      op_sum_carry,
      op_minus_borrow,
      op_increment,
      op_decrement,
      op_inc_pointer,
      op_multiply,
      op_divide,
      op_bcd_adjust,
      op_and,
      op_or,
      op_xor,
      op_clear_acc,
      op_invert_acc,
      op_rotate_left,
      op_rotate_left_c,
      op_rotate_right,
      op_rotate_right_c,
      op_swap_nibble,
      op_load_code,
      op_load_bit
   } bca_op_t;

   // operand addressing form
   typedef enum logic [3:0] {
      md_reg,
      md_direct,
      md_indirect,
      md_imm,
      md_acc,
      md_dir_acc,
      md_dir_imm,
      md_indexed,
      md_bit
   } bca_mode_t;

   typedef enum logic {
      st_idle,
      st_run
   } bca_state_t;

   // memory space codes on the memory port
   localparam logic [1:0] SPACE_IRAM = 2'h0;
   localparam logic [1:0] SPACE_SPECIAL = 2'h1;
   localparam logic [1:0] SPACE_CODE = 2'h2;

   // address map
   localparam logic [7:0] SPECIAL_BASE  = 8'h80;
   localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
   localparam int         WREG_BYTES    = 32;

   // reset values
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [7:0]  B_RST    = 8'h00;
   localparam logic [15:0] PTR_RST  = 16'h0000;
   localparam logic        FLAG_RST = 1'b0;

   // instruction lengths in clock cycles
   localparam logic [2:0] CYC_SHORT      = 3'h1;
   localparam logic [2:0] CYC_MEM_SRC    = 3'h2;
   localparam logic [2:0] CYC_REG_INCDEC = 3'h2;
   localparam logic [2:0] CYC_RMW        = 3'h3;
   localparam logic [2:0] CYC_MUL        = 3'h2;
   localparam logic [2:0] CYC_DIV        = 3'h6;
   localparam logic [2:0] CYC_BCD        = 3'h3;
   localparam logic [2:0] CYC_CODE_IDX   = 3'h5;
   localparam logic [2:0] CYC_BIT        = 3'h2;

endpackage

// >>> rtl/bca_alu.sv
`timescale 1ns/1ns
module bca_alu (
   input  wire bca_pkg::bca_op_t i_op,
   input  wire logic [7:0]       i_a,
   input  wire logic [7:0]       i_b,
   input  wire logic             i_cy,
   input  wire logic             i_ac,
   input  wire logic             i_ov,
   output logic      [7:0]       o_res,
   output logic      [7:0]       o_hi,
   output logic                  o_cy,
   output logic                  o_ac,
   output logic                  o_ov
);

   logic [8:0]  sum9;
   logic [4:0]  nib5;
   logic [8:0]  dif9;
   logic [4:0]  nibd5;
   logic [15:0] prod;
   logic [8:0]  bcd9;
   logic        cin;
   logic        b_zero;

   assign cin    = (i_op == bca_pkg::op_sum_carry || i_op == bca_pkg::op_minus_borrow) ? i_cy : 1'b0;
   assign sum9   = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
   assign nib5   = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
   assign dif9   = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
   assign nibd5  = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, cin};
   assign prod   = i_a * i_b;
   assign b_zero = (i_b == 8'h00);

   always_comb begin
      bcd9 = {1'b0, i_a};
      if (i_a[3:0] > 4'h9 || i_ac) begin // RQ20
         bcd9 = bcd9 + 9'h006;
      end
      if (bcd9[7:4] > 4'h9 || bcd9[8] || i_cy) begin // RQ20
         bcd9 = bcd9 + 9'h060;
      end
   end

   always_comb begin
      o_res = i_a;
      o_hi  = i_b;
      o_cy  = i_cy;
      o_ac  = i_ac;
      o_ov  = i_ov;
      case (i_op)
         bca_pkg::op_add, bca_pkg::op_sum_carry: begin // RQ6
            o_res = sum9[7:0];
            o_cy  = sum9[8]; // RQ22
            o_ac  = nib5[4]; // RQ22
            o_ov  = ~(i_a[7] ^ i_b[7]) & (i_a[7] ^ sum9[7]); // RQ22
         end
         bca_pkg::op_minus_borrow: begin // RQ7
            o_res = dif9[7:0];
            o_cy  = dif9[8]; // RQ22
            o_ac  = nibd5[4]; // RQ22
            o_ov  = (i_a[7] ^ i_b[7]) & (i_a[7] ^ dif9[7]); // RQ22
         end
         bca_pkg::op_increment:     o_res = i_a + 8'h01; // RQ8
         bca_pkg::op_decrement:     o_res = i_a - 8'h01; // RQ8
         bca_pkg::op_multiply: begin // RQ9
            o_res = prod[7:0]; // RQ21
            o_hi  = prod[15:8]; // RQ21
            o_cy  = 1'b0;
            o_ov  = (prod[15:8] != 8'h00);
         end
         bca_pkg::op_divide: begin // RQ10
            o_cy = 1'b0;
            o_ov = b_zero; // RQ21
            if (!b_zero) begin
               o_res = i_a / i_b; // RQ21
               o_hi  = i_a % i_b; // RQ21
            end
         end
         bca_pkg::op_bcd_adjust: begin
            o_res = bcd9[7:0]; // RQ20
            o_cy  = i_cy | bcd9[8];
         end
         bca_pkg::op_and:            o_res = i_a & i_b; // RQ11
         bca_pkg::op_or:             o_res = i_a | i_b; // RQ11
         bca_pkg::op_xor:            o_res = i_a ^ i_b; // RQ11
         bca_pkg::op_clear_acc:      o_res = 8'h00; // RQ15
         bca_pkg::op_invert_acc:     o_res = ~i_a; // RQ15
         bca_pkg::op_rotate_left:    o_res = {i_a[6:0], i_a[7]}; // RQ15
         bca_pkg::op_rotate_left_c: begin // RQ15
            o_res = {i_a[6:0], i_cy};
            o_cy  = i_a[7];
         end
         bca_pkg::op_rotate_right:   o_res = {i_a[0], i_a[7:1]}; // RQ16
         bca_pkg::op_rotate_right_c: begin // RQ16
            o_res = {i_cy, i_a[7:1]};
            o_cy  = i_a[0];
         end
         bca_pkg::op_swap_nibble:    o_res = {i_a[3:0], i_a[7:4]}; // RQ17
         bca_pkg::op_load_code:      o_res = i_b;
         default:                    o_res = i_a;
      endcase
   end

endmodule

// >>> rtl/bca_core.sv
// What this block does
// RQ1: direct mode uses an 8-bit address reaching internal RAM or special registers only.
// RQ2: indirect mode takes 8-bit address from register 0/1, 16-bit from data pointer; only the register 0/1 form is built.
// RQ3: register mode picks one of eight registers in the current bank.
// RQ4: indexed mode only reads program memory at data pointer plus accumulator.
// RQ5: bit mode selects one bit out of 256 addressable bits.
// RQ6: add and add-with-carry: register 1 cycle, direct/indirect/immediate 2 cycles.
// RQ7: subtract-with-borrow removes operand and carry, same timing as add.
// RQ8: inc/dec: accumulator 1, register 2, direct/indirect 3; pointer increment 1.
// RQ9: multiply accumulator by B in 2 cycles.
// RQ10: divide accumulator by B in 6 cycles.
// RQ11: AND, OR, XOR act on each bit position independently.
// RQ12: AND: register 1, other sources 2, into a direct byte 3 cycles.
// RQ13: OR has the same forms and timing as AND.
// RQ14: XOR has the same forms and timing as AND.
// RQ15: rotate left plain and through carry, clear, complement: 1 cycle each.
// RQ16: rotate right plain and through carry: 1 cycle each.
// RQ17: nibble swap of accumulator in 1 cycle.
// RQ18: most operations finish within one to two cycles.
// RQ19: external reset is active low with pull-up, handled outside this block.
// RQ20: decimal adjust in 3 cycles adds 6 per nibble above nine or flagged.
// RQ21: multiply low to A high to B; divide quotient A remainder B; zero sets overflow.
// RQ22: add and subtract set carry, auxiliary carry and overflow from the result.
`timescale 1ns/1ns
module bca_core (
   input  wire logic                  i_clk,
   input  wire logic                  i_srst,
   input  wire logic                  i_start,
   input  wire bca_pkg::bca_op_t      i_op,
   input  wire bca_pkg::bca_mode_t    i_mode,
   input  wire logic [2:0]            i_reg_sel,
   input  wire logic [1:0]            i_bank,
   input  wire logic [7:0]            i_addr8,
   input  wire logic [7:0]            i_imm8,
   input  wire logic [7:0]            i_mem_rdata,
   output logic                       o_busy,
   output logic                       o_done,
   output logic                       o_illegal,
   output logic                       o_mem_rd,
   output logic                       o_mem_wr,
   output logic [1:0]                 o_mem_space,
   output logic [15:0]                o_mem_addr,
   output logic [7:0]                 o_mem_wdata,
   output logic [7:0]                 o_acc,
   output logic [7:0]                 o_b,
   output logic                       o_carry,
   output logic                       o_aux_carry,
   output logic                       o_overflow,
   output logic [15:0]                o_data_pointer_16
);

   bca_pkg::bca_state_t state_r;
   bca_pkg::bca_op_t    op_r;
   bca_pkg::bca_mode_t  mode_r;
   logic [7:0]          wreg_r [0:bca_pkg::WREG_BYTES-1];
   logic [2:0]          len_r;
   logic [2:0]          cnt_r;
   logic                ext_rd_r;
   logic                dst_ext_r;
   logic                dst_int_r;
   logic [4:0]          dst_idx_r;
   logic [7:0]          opnd_r;
   logic [7:0]          src2_r;
   logic [2:0]          bit_r;
   logic [7:0]          acc_r;
   logic [7:0]          b_r;
   logic [15:0]         ptr_r;
   logic                cy_r;
   logic                ac_r;
   logic                ov_r;

   // cycle count per operation and form; zero marks an illegal pairing
   function automatic logic [2:0] op_len(input bca_pkg::bca_op_t op, input bca_pkg::bca_mode_t md);
      logic [2:0] n;
      n = 3'h0;
      case (op)
         bca_pkg::op_add, bca_pkg::op_sum_carry, bca_pkg::op_minus_borrow,
         bca_pkg::op_and, bca_pkg::op_or, bca_pkg::op_xor: begin
            case (md)
               bca_pkg::md_reg:      n = bca_pkg::CYC_SHORT; // RQ6 RQ7 RQ12
               bca_pkg::md_direct,
               bca_pkg::md_indirect,
               bca_pkg::md_imm:      n = bca_pkg::CYC_MEM_SRC; // RQ6 RQ7 RQ12
               bca_pkg::md_dir_acc,
               bca_pkg::md_dir_imm:  n = (op == bca_pkg::op_and || op == bca_pkg::op_or || op == bca_pkg::op_xor)
                                         ? bca_pkg::CYC_RMW : 3'h0; // RQ12 RQ13 RQ14
               default:              n = 3'h0;
            endcase
         end
         bca_pkg::op_increment, bca_pkg::op_decrement: begin
            case (md)
               bca_pkg::md_acc:      n = bca_pkg::CYC_SHORT; // RQ8
               bca_pkg::md_reg:      n = bca_pkg::CYC_REG_INCDEC; // RQ8
               bca_pkg::md_direct,
               bca_pkg::md_indirect: n = bca_pkg::CYC_RMW; // RQ8
               default:              n = 3'h0;
            endcase
         end
         bca_pkg::op_inc_pointer:    n = bca_pkg::CYC_SHORT; // RQ8
         bca_pkg::op_multiply:       n = bca_pkg::CYC_MUL; // RQ9
         bca_pkg::op_divide:         n = bca_pkg::CYC_DIV; // RQ10
         bca_pkg::op_bcd_adjust:     n = bca_pkg::CYC_BCD; // RQ20
         bca_pkg::op_clear_acc, bca_pkg::op_invert_acc,
         bca_pkg::op_rotate_left, bca_pkg::op_rotate_left_c,
         bca_pkg::op_rotate_right, bca_pkg::op_rotate_right_c,
         bca_pkg::op_swap_nibble:    n = bca_pkg::CYC_SHORT; // RQ15 RQ16 RQ17 RQ18
         bca_pkg::op_load_code:      n = (md == bca_pkg::md_indexed) ? bca_pkg::CYC_CODE_IDX : 3'h0; // RQ4
         bca_pkg::op_load_bit:       n = (md == bca_pkg::md_bit) ? bca_pkg::CYC_BIT : 3'h0; // RQ5
         default:                    n = 3'h0;
      endcase
      return n;
   endfunction

   // start decode
   wire        idle_w     = (state_r == bca_pkg::st_idle);
   wire [2:0]  len_w      = op_len(i_op, i_mode);
   wire        take_w     = idle_w && i_start && (len_w != 3'h0);
   wire        refuse_w   = idle_w && i_start && (len_w == 3'h0);
   wire [4:0]  reg_idx_w  = {i_bank, i_reg_sel}; // RQ3
   wire [7:0]  ind_ptr_w  = wreg_r[{i_bank, 2'b00, i_reg_sel[0]}]; // RQ2
   wire [7:0]  bit_byte_w = i_addr8[7] ? {i_addr8[7:3], 3'b000}
                                       : (bca_pkg::BIT_BYTE_BASE + {4'h0, i_addr8[6:3]}); // RQ5
   wire [7:0]  addr8_w    = (i_mode == bca_pkg::md_indirect) ? ind_ptr_w :
                            (i_mode == bca_pkg::md_bit) ? bit_byte_w : i_addr8; // RQ1 RQ2
   wire [15:0] code_adr_w = ptr_r + {8'h00, acc_r}; // RQ4
   wire        indexed_w  = (i_mode == bca_pkg::md_indexed);
   wire [1:0]  space_w    = indexed_w ? bca_pkg::SPACE_CODE :
                            (i_mode == bca_pkg::md_indirect) ? bca_pkg::SPACE_IRAM :
                            (addr8_w >= bca_pkg::SPECIAL_BASE) ? bca_pkg::SPACE_SPECIAL : bca_pkg::SPACE_IRAM; // RQ1
   wire        mem_mode_w = (i_mode == bca_pkg::md_direct) || (i_mode == bca_pkg::md_indirect) ||
                            (i_mode == bca_pkg::md_dir_acc) || (i_mode == bca_pkg::md_dir_imm) ||
                            (i_mode == bca_pkg::md_bit) || indexed_w;
   // low iram bytes are the working registers held here
   wire        in_wreg_w  = !indexed_w && (space_w == bca_pkg::SPACE_IRAM) && (addr8_w[7:5] == 3'b000);
   wire        ext_rd_w   = mem_mode_w && !in_wreg_w;
   wire        incdec_w   = (i_op == bca_pkg::op_increment) || (i_op == bca_pkg::op_decrement);
   wire        mem_dst_w  = (i_mode == bca_pkg::md_dir_acc) || (i_mode == bca_pkg::md_dir_imm) ||
                            (incdec_w && (i_mode == bca_pkg::md_direct || i_mode == bca_pkg::md_indirect));
   wire        reg_dst_w  = incdec_w && (i_mode == bca_pkg::md_reg);
   wire [7:0]  opnd_w     = (i_mode == bca_pkg::md_reg) ? wreg_r[reg_idx_w] : // RQ3
                            (i_mode == bca_pkg::md_imm) ? i_imm8 :
                            in_wreg_w ? wreg_r[addr8_w[4:0]] : 8'h00;
   wire [7:0]  src2_w     = (i_mode == bca_pkg::md_dir_acc) ? acc_r : i_imm8;

   // execution phase
   wire        run_w      = (state_r == bca_pkg::st_run);
   wire        last_w     = run_w && (cnt_r == len_r);
   wire        pre_wr_w   = run_w && dst_ext_r && (cnt_r == len_r - 3'h1);
   wire        tgt_oth_w  = dst_ext_r || dst_int_r;
   wire        two_src_w  = (mode_r == bca_pkg::md_dir_acc) || (mode_r == bca_pkg::md_dir_imm);
   wire [7:0]  alu_a_w    = tgt_oth_w ? opnd_r : acc_r;
   wire [7:0]  alu_b_w    = two_src_w ? src2_r :
                            (op_r == bca_pkg::op_multiply || op_r == bca_pkg::op_divide) ? b_r : opnd_r;
   wire        acc_we_w   = last_w && !tgt_oth_w && (op_r != bca_pkg::op_inc_pointer) &&
                            (op_r != bca_pkg::op_load_bit);
   wire        b_we_w     = last_w && (op_r == bca_pkg::op_multiply || op_r == bca_pkg::op_divide);
   wire        bit_w      = opnd_r[bit_r];

   logic [7:0] alu_res;
   logic [7:0] alu_hi;
   logic       alu_cy;
   logic       alu_ac;
   logic       alu_ov;

   bca_alu u_alu (
      .i_op  (op_r),
      .i_a   (alu_a_w),
      .i_b   (alu_b_w),
      .i_cy  (cy_r),
      .i_ac  (ac_r),
      .i_ov  (ov_r),
      .o_res (alu_res),
      .o_hi  (alu_hi),
      .o_cy  (alu_cy),
      .o_ac  (alu_ac),
      .o_ov  (alu_ov)
   );

   // sequencer
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_r <= bca_pkg::st_idle;
         cnt_r   <= 3'h0;
      end else if (take_w) begin
         state_r <= bca_pkg::st_run;
         cnt_r   <= 3'h1;
      end else if (last_w) begin
         state_r <= bca_pkg::st_idle;
         cnt_r   <= 3'h0;
      end else if (run_w) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   // latched instruction context
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         op_r      <= bca_pkg::op_add;
         mode_r    <= bca_pkg::md_acc;
         len_r     <= 3'h0;
         ext_rd_r  <= 1'b0;
         dst_ext_r <= 1'b0;
         dst_int_r <= 1'b0;
         dst_idx_r <= 5'h00;
         src2_r    <= 8'h00;
         bit_r     <= 3'h0;
      end else if (take_w) begin
         op_r      <= i_op;
         mode_r    <= i_mode;
         len_r     <= len_w;
         ext_rd_r  <= ext_rd_w;
         dst_ext_r <= mem_dst_w && !in_wreg_w;
         dst_int_r <= (mem_dst_w && in_wreg_w) || reg_dst_w;
         dst_idx_r <= reg_dst_w ? reg_idx_w : addr8_w[4:0];
         src2_r    <= src2_w;
         bit_r     <= i_addr8[2:0]; // RQ5
      end
   end

   // operand: taken at start, or from memory in the read cycle
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         opnd_r <= 8'h00;
      end else if (take_w) begin
         opnd_r <= opnd_w;
      end else if (run_w && ext_rd_r && cnt_r == 3'h1) begin
         opnd_r <= i_mem_rdata; // RQ1 RQ2 RQ4
      end
   end

   // memory port
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_mem_rd    <= 1'b0;
         o_mem_wr    <= 1'b0;
         o_mem_space <= bca_pkg::SPACE_IRAM;
         o_mem_addr  <= 16'h0000;
         o_mem_wdata <= 8'h00;
      end else begin
         o_mem_rd <= take_w && ext_rd_w;
         o_mem_wr <= pre_wr_w; // RQ12 RQ13 RQ14
         if (take_w) begin
            o_mem_space <= space_w;
            o_mem_addr  <= indexed_w ? code_adr_w : {8'h00, addr8_w};
         end
         if (pre_wr_w) begin
            o_mem_wdata <= alu_res;
         end
      end
   end

   // working register bytes, data only
   always_ff @(posedge i_clk) begin
      if (last_w && dst_int_r) begin
         wreg_r[dst_idx_r] <= alu_res; // RQ3 RQ8
      end
   end

   // architectural state
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         acc_r  <= bca_pkg::ACC_RST;
         b_r    <= bca_pkg::B_RST;
         ptr_r  <= bca_pkg::PTR_RST;
         cy_r   <= bca_pkg::FLAG_RST;
         ac_r   <= bca_pkg::FLAG_RST;
         ov_r   <= bca_pkg::FLAG_RST;
      end else if (last_w) begin
         if (acc_we_w) begin
            acc_r <= alu_res;
         end
         if (b_we_w) begin
            b_r <= alu_hi; // RQ21
         end
         if (op_r == bca_pkg::op_inc_pointer) begin
            ptr_r <= ptr_r + 16'h0001; // RQ8
         end
         cy_r <= (op_r == bca_pkg::op_load_bit) ? bit_w : alu_cy; // RQ5 RQ22
         ac_r <= alu_ac;
         ov_r <= alu_ov;
      end
   end

   // status outputs
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_busy    <= 1'b0;
         o_done    <= 1'b0;
         o_illegal <= 1'b0;
      end else begin
         o_busy    <= take_w || (run_w && !last_w);
         o_done    <= last_w; // RQ18
         o_illegal <= refuse_w;
      end
   end

   assign o_acc       = acc_r;
   assign o_b         = b_r;
   assign o_carry     = cy_r;
   assign o_aux_carry = ac_r;
   assign o_overflow  = ov_r;
   assign o_data_pointer_16 = ptr_r;

endmodule

// >>> testbench/bca_core_props.sv
`timescale 1ns/1ns
module bca_core_props (
   input wire logic               i_clk,
   input wire logic               i_srst,
   input wire logic               i_start,
   input wire bca_pkg::bca_op_t   i_op,
   input wire bca_pkg::bca_mode_t i_mode,
   input wire logic               o_busy,
   input wire logic               o_done,
   input wire logic               o_illegal,
   input wire logic               o_mem_rd,
   input wire logic               o_mem_wr,
   input wire logic [1:0]         o_mem_space,
   input wire logic [15:0]        o_mem_addr,
   input wire logic [7:0]         o_acc,
   input wire logic [15:0]        o_data_pointer_16
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   wire take = i_start && !o_busy;

   special_read_map_a: assert property (o_mem_rd && o_mem_space == bca_pkg::SPACE_SPECIAL |-> o_mem_addr[7])
      else $error("special read below upper half");
   code_read_addr_a: assert property (o_mem_rd && o_mem_space == bca_pkg::SPACE_CODE |->
      o_mem_addr == o_data_pointer_16 + {8'h00, o_acc}) else $error("code read address wrong");
   write_last_a: assert property (o_mem_wr |=> o_done && !o_busy) else $error("write not in last cycle");
   rmw_same_addr_a: assert property (o_mem_wr |-> $past(o_mem_rd, 2) && o_mem_addr == $past(o_mem_addr, 2))
      else $error("write without matching read");
   mul_length_a: assert property (take && i_op == bca_pkg::op_multiply |=> o_busy ##1 o_busy ##1 o_done)
      else $error("multiply length wrong");
   div_length_a: assert property (take && i_op == bca_pkg::op_divide |=> o_busy [*6] ##1 o_done)
      else $error("divide length wrong");
   swap_result_a: assert property (take && i_op == bca_pkg::op_swap_nibble |=>
      o_busy ##1 (o_done && o_acc == {$past(o_acc[3:0], 2), $past(o_acc[7:4], 2)})) else $error("swap wrong");
   illegal_pair_a: assert property (take && i_op == bca_pkg::op_add && i_mode == bca_pkg::md_indexed |=>
      o_illegal && !o_busy && $stable(o_acc)) else $error("illegal pair accepted");
   wr_cover_c: cover property (o_mem_wr);
   ill_cover_c: cover property (o_illegal);
   div_cover_c: cover property (take && i_op == bca_pkg::op_divide);
endmodule
bind bca_core bca_core_props u_props (.i_clk, .i_srst, .i_start, .i_op, .i_mode, .o_busy, .o_done, .o_illegal,
   .o_mem_rd, .o_mem_wr, .o_mem_space, .o_mem_addr, .o_acc, .o_data_pointer_16);

// >>> testbench/bca_mem_model.sv
`timescale 1ns/1ns
module bca_mem_model (
   input  wire logic        i_clk,
   input  wire logic        i_rd,
   input  wire logic        i_wr,
   input  wire logic [1:0]  i_space,
   input  wire logic [15:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   output logic      [7:0]  o_rdata
);
   logic [7:0] mem [0:511];
   logic [7:0] last_r = 8'h00;
   wire  [8:0] idx = {i_space[0], i_addr[7:0]};
   wire  [7:0] val = (i_space == 2'h2) ? (i_addr[15:8] ^ i_addr[7:0] ^ 8'h3C) : mem[idx];
   initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ {7'h00, i[8]} ^ 8'hA5;
   // undriven read bus shows the inverse of the last byte
   assign o_rdata = i_rd ? val : ~last_r;
   always @(posedge i_clk) begin
      if (i_rd) last_r <= val;
      if (i_wr) mem[idx] <= i_wdata;
   end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic               i_clk = 0, i_srst = 1, i_start = 0;
   bca_pkg::bca_op_t   i_op = bca_pkg::op_add, op;
   bca_pkg::bca_mode_t i_mode = bca_pkg::md_reg;
   logic [2:0]         i_reg_sel = 0;
   logic [1:0]         i_bank = 0, o_mem_space;
   logic [7:0]         i_addr8 = 0, i_imm8 = 0, i_mem_rdata, o_acc, o_b, o_mem_wdata, acc = 0, b = 0, m [0:511];
   logic [15:0]        o_mem_addr, o_data_pointer_16, dp = 0;
   logic               o_busy, o_done, o_illegal, o_mem_rd, o_mem_wr, o_carry, o_aux_carry, o_overflow;
   logic               cy = 0, ac = 0, ov = 0;
   int                 n_errors = 0, check_count = 0, seed = 5208, cyc = 0, rnd;

   bca_core i_dut (.*);
   bca_mem_model u_mem (.i_clk(i_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_space(o_mem_space),
      .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

   initial forever #4 i_clk = ~i_clk;

   task automatic report_and_stop;
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic bca_pkg::bca_mode_t pick(input bca_pkg::bca_op_t op, input logic [2:0] r);
      if (op <= bca_pkg::op_minus_borrow) return bca_pkg::bca_mode_t'({2'h0, r[1:0]});
      if (op >= bca_pkg::op_and && op <= bca_pkg::op_xor)
         return bca_pkg::bca_mode_t'(r[2] ? 4'h5 + r[0] : {2'h0, r[1:0]});
      if (op <= bca_pkg::op_decrement) return bca_pkg::bca_mode_t'(r[1:0] == 2'h3 ? 4'h4 : {2'h0, r[1:0]});
      if (op == bca_pkg::op_load_code) return bca_pkg::md_indexed;
      return op == bca_pkg::op_load_bit ? bca_pkg::md_bit : bca_pkg::md_acc;
   endfunction

   // reference step, then drive at the falling edge and compare at done
   task automatic run_op(input bca_pkg::bca_op_t op, input bca_pkg::bca_mode_t md, input logic [2:0] rs,
                         input logic [1:0] bk, input logic [7:0] ad, input logic [7:0] im);
      logic [8:0]  ti, sum;
      logic [4:0]  lo;
      logic [7:0]  s, t, r, a0;
      logic [15:0] pr;
      logic        wt, bad, ci, sb;
      int          n, c;
      wt = 0;
      a0 = acc;
      bad = md == bca_pkg::md_indexed && op != bca_pkg::op_load_code;
      case (md)
         bca_pkg::md_reg:      ti = {4'h0, bk, rs};
         bca_pkg::md_indirect: ti = {1'b0, m[{4'h0, bk, 2'h0, rs[0]}]};
         default:              ti = {ad[7], ad};
      endcase
      s = md == bca_pkg::md_imm ? im : md == bca_pkg::md_acc ? acc : m[ti];
      t = md == bca_pkg::md_dir_imm ? im : acc;
      n = (md == bca_pkg::md_reg || md == bca_pkg::md_acc) ? 1 :
          (md == bca_pkg::md_dir_acc || md == bca_pkg::md_dir_imm) ? 3 : 2;
      if (!bad) case (op)
         bca_pkg::op_add, bca_pkg::op_sum_carry, bca_pkg::op_minus_borrow: begin
            ci = op != bca_pkg::op_add && cy;
            sb = op == bca_pkg::op_minus_borrow;
            sum = sb ? {1'b0, acc} - {1'b0, s} - ci : {1'b0, acc} + {1'b0, s} + ci;
            lo = sb ? {1'b0, acc[3:0]} - {1'b0, s[3:0]} - ci : {1'b0, acc[3:0]} + {1'b0, s[3:0]} + ci;
            ov = ((acc[7] ^ s[7]) == sb) && (sum[7] != acc[7]);
            {cy, ac, acc} = {sum[8], lo[4], sum[7:0]};
         end
         bca_pkg::op_increment, bca_pkg::op_decrement: begin
            r = op == bca_pkg::op_increment ? s + 8'h01 : s - 8'h01;
            n = md == bca_pkg::md_acc ? 1 : md == bca_pkg::md_reg ? 2 : 3;
            wt = md != bca_pkg::md_acc;
            if (wt) m[ti] = r;
            else acc = r;
         end
         bca_pkg::op_and, bca_pkg::op_or, bca_pkg::op_xor: begin
            r = op == bca_pkg::op_and ? s & t : op == bca_pkg::op_or ? s | t : s ^ t;
            wt = n == 3;
            if (wt) m[ti] = r;
            else acc = r;
         end
         bca_pkg::op_inc_pointer:    dp = dp + 16'h0001;
         bca_pkg::op_multiply: begin
            n = 2;
            {b, acc} = acc * b;
            {cy, ov} = {1'b0, b != 8'h00};
         end
         bca_pkg::op_divide: begin
            n = 6;
            {cy, ov} = {1'b0, b == 8'h00};
            if (!ov) {acc, b} = {acc / b, acc % b};
         end
         bca_pkg::op_bcd_adjust: begin
            n = 3;
            sum = {1'b0, acc} + ((acc[3:0] > 4'h9 || ac) ? 9'h006 : 9'h000);
            cy = cy | sum[8];
            sum = {1'b0, sum[7:0]} + ((sum[7:4] > 4'h9 || cy) ? 9'h060 : 9'h000);
            {cy, acc} = {cy | sum[8], sum[7:0]};
         end
         bca_pkg::op_clear_acc:      acc = 8'h00;
         bca_pkg::op_invert_acc:     acc = ~acc;
         bca_pkg::op_rotate_left:    acc = {acc[6:0], acc[7]};
         bca_pkg::op_rotate_left_c:  {cy, acc} = {acc, cy};
         bca_pkg::op_rotate_right:   acc = {acc[0], acc[7:1]};
         bca_pkg::op_rotate_right_c: {acc, cy} = {cy, acc};
         bca_pkg::op_swap_nibble:    acc = {acc[3:0], acc[7:4]};
         bca_pkg::op_load_code: begin
            n = 5;
            pr = dp + {8'h00, acc};
            acc = pr[15:8] ^ pr[7:0] ^ 8'h3C;
         end
         default: begin
            n = 2;
            r = m[ad[7] ? {1'b1, ad[7:3], 3'h0} : {5'h02, ad[6:3]}];
            cy = r[ad[2:0]];
         end
      endcase
      i_op = op;
      i_mode = md;
      {i_reg_sel, i_bank, i_addr8, i_imm8, i_start} = {rs, bk, ad, im, 1'b1};
      @(negedge i_clk);
      i_start = 1'b0;
      if (bad) begin
         chk_val({o_illegal, o_busy, 6'h00, o_acc}, {2'h2, 6'h00, a0});
         @(negedge i_clk);
      end else begin
         c = 1;
         while (o_done !== 1'b1 && c < 12) begin
            @(negedge i_clk);
            c++;
         end
         chk_val(16'(c), 16'(n + 1));
         chk_val({o_b, o_acc}, {b, acc});
         chk_val({13'h0, o_carry, o_aux_carry, o_overflow}, {13'h0, cy, ac, ov});
         chk_val(o_data_pointer_16, dp);
         if (wt && ti > 9'd31) chk_val({8'h00, u_mem.mem[ti]}, {8'h00, m[ti]});
      end
   endtask

   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 12000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      for (int i = 0; i < 512; i++) m[i] = i[7:0] ^ {7'h00, i[8]} ^ 8'hA5;
      repeat (2) @(negedge i_clk);
      i_srst = 1'b0;
      @(negedge i_clk);
      chk_val({o_b, o_acc}, 16'h0000);
      for (int i = 0; i < 32; i++) begin
         rnd = $random(seed);
         run_op(bca_pkg::op_and, bca_pkg::md_dir_imm, 3'h0, 2'h0, i[7:0], 8'h00);
         run_op(bca_pkg::op_or, bca_pkg::md_dir_imm, 3'h0, 2'h0, i[7:0], rnd[7:0]);
      end
      run_op(bca_pkg::op_add, bca_pkg::md_indexed, 3'h0, 2'h0, 8'h00, 8'h00);
      for (int k = 0; k < 421; k++) begin
         rnd = $random(seed);
         op = bca_pkg::bca_op_t'(k < 21 ? k : rnd[12:8] % 21);
         run_op(op, pick(op, rnd[15:13]), rnd[18:16], rnd[20:19], rnd[7:0], rnd[28:21]);
      end
      report_and_stop();
   end
endmodule
